/* File: inc/pss_defs.svh */
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
// timing figures
`define PSS_CLK_HZ 25000000
`define PSS_HOLD_S 4
`define PSS_HOLD_CYC (`PSS_CLK_HZ * `PSS_HOLD_S)
`define PSS_DEB_US 10000
`define PSS_DEB_CYC ((`PSS_CLK_HZ / 1000000) * `PSS_DEB_US)
`define PSS_CNT_W 27
`endif

/* File: inc/pss_pkg.sv */
package pss_pkg;
  // global power states, one-hot
  typedef enum logic [2:0] {
    pss_soft_off = 3'h1,
    pss_working = 3'h2,
    pss_sleeping = 3'h4
  } pss_state_t;
endpackage : pss_pkg

/* File: logic/pss_debounce.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pss_defs.svh"
// =====================================================
// switch debouncer
module pss_debounce #(
  parameter int DEB_CYC = `PSS_DEB_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic raw,
  output logic clean
);
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic next_clean;

  // restart count whenever raw agrees with clean
  always_comb begin
    next_cnt = 24'h00_0000;
    next_clean = clean;
    if (raw != clean) begin
      if (cnt >= 24'(DEB_CYC - 1)) begin
        next_clean = raw;
      end else begin
        next_cnt = cnt + 24'h00_0001;
      end
    end
  end

  // count and clean level registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt <= 24'h00_0000;
      clean <= 1'b0;
    end else begin
      cnt <= next_cnt;
      clean <= next_clean;
    end
  end

  // =====================================================
  // checks
  // a level differing for DEB_CYC samples is taken over
  a_deb_take: assert property (
    @(posedge clock) disable iff (!nrst)
    (raw != clean && cnt >= 24'(DEB_CYC - 1))
    |=> clean == $past(raw))
    else $error("debounce did not take level");
  // anything shorter leaves the clean level alone
  a_deb_keep: assert property (
    @(posedge clock) disable iff (!nrst)
    (raw == clean || cnt < 24'(DEB_CYC - 1))
    |=> $stable(clean))
    else $error("debounce level moved early");
  // agreement restarts the count
  a_deb_restart: assert property (
    @(posedge clock) disable iff (!nrst)
    raw == clean |=> cnt == 24'h00_0000)
    else $error("debounce count not cleared");
endmodule : pss_debounce
`default_nettype wire

/* File: logic/pss_power_switch.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pss_defs.svh"
// Notes on behaviour
// - off, short press goes working
// - working, short press goes sleeping
// - working, long press forces soft off
// - sleeping, short press wakes to working
// - sleeping, long press powers off
// =====================================================
// power switch state control
module pss_power_switch #(
  parameter int HOLD_CYC = `PSS_HOLD_CYC,
  parameter int DEB_CYC = `PSS_DEB_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sw_pressed,
  output logic [2:0] gstate,
  output logic power_on,
  output logic sleep
);
  // debounced switch level and its copy one cycle back
  logic pressed;
  logic was_pressed;
  // press timer; expired marks a hold that already acted as long
  logic expired;
  logic [`PSS_CNT_W-1:0] hold;
  logic [`PSS_CNT_W-1:0] next_hold;
  logic next_expired;
  // global power state
  pss_pkg::pss_state_t st;
  pss_pkg::pss_state_t next_st;
  // next values of the pin registers
  logic [2:0] next_gstate;
  logic next_power_on;
  logic next_sleep;

  // =====================================================
  // debounced switch
  // the raw contact chatters; only a level held for DEB_CYC
  // cycles reaches the timer, so one press is one event
  pss_debounce #(.DEB_CYC(DEB_CYC)) pss_debounce_i (
    .clock(clock),
    .nrst(nrst),
    .raw(sw_pressed),
    .clean(pressed)
  );

  // =====================================================
  // press timer and global state
  // press timer, long press acts on expiry, short on release
  // a hold reaching the threshold acts at once; its release is
  // swallowed, so a long press never also counts as short
  always_comb begin
    next_hold = hold;
    next_expired = expired;
    next_st = st;
    if (pressed) begin
      if (!expired && hold >= `PSS_CNT_W'(HOLD_CYC - 1)) begin
        next_expired = 1'b1;
        if (st != pss_pkg::pss_soft_off) begin
          next_st = pss_pkg::pss_soft_off;
        end
      end else if (!expired) begin
        next_hold = hold + `PSS_CNT_W'(1);
      end
    end else begin
      next_hold = '0;
      next_expired = 1'b0;
      if (was_pressed && !expired) begin
        case (st)
          pss_pkg::pss_soft_off: next_st = pss_pkg::pss_working;
          pss_pkg::pss_working: next_st = pss_pkg::pss_sleeping;
          pss_pkg::pss_sleeping: next_st = pss_pkg::pss_working;
          default: next_st = pss_pkg::pss_soft_off;
        endcase
      end
    end
  end

  // timer and state registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hold <= '0;
      expired <= 1'b0;
      was_pressed <= 1'b0;
      st <= pss_pkg::pss_soft_off;
    end else begin
      hold <= next_hold;
      expired <= next_expired;
      was_pressed <= pressed;
      st <= next_st;
    end
  end

  // =====================================================
  // pin outputs
  // decoded from next_st so the pins move on the same edge as st
  always_comb begin
    next_gstate = 3'(next_st);
    next_power_on = (next_st == pss_pkg::pss_working);
    next_sleep = (next_st == pss_pkg::pss_sleeping);
  end

  // pin registers, reset to soft off with both levels low
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gstate <= 3'(pss_pkg::pss_soft_off);
      power_on <= 1'b0;
      sleep <= 1'b0;
    end else begin
      gstate <= next_gstate;
      power_on <= next_power_on;
      sleep <= next_sleep;
    end
  end

  // =====================================================
  // checks
  // short press from soft off powers on
  a_short_off_on: assert property (
    @(posedge clock) disable iff (!nrst)
    (!pressed && was_pressed && !expired && st == pss_pkg::pss_soft_off)
    |=> st == pss_pkg::pss_working && power_on && !sleep)
    else $error("off short press");

  // short press while working goes to sleep
  a_short_work_slp: assert property (
    @(posedge clock) disable iff (!nrst)
    (!pressed && was_pressed && !expired && st == pss_pkg::pss_working)
    |=> st == pss_pkg::pss_sleeping && sleep && !power_on)
    else $error("work short press");

  // long press while working forces soft off at expiry
  a_long_work_off: assert property (
    @(posedge clock) disable iff (!nrst)
    (pressed && !expired && st == pss_pkg::pss_working
     && hold == `PSS_CNT_W'(HOLD_CYC - 1))
    |=> st == pss_pkg::pss_soft_off && !power_on && !sleep ##1 !power_on)
    else $error("work long press");

  // short press while sleeping wakes and stays awake
  a_short_slp_wake: assert property (
    @(posedge clock) disable iff (!nrst)
    (!pressed && was_pressed && !expired && st == pss_pkg::pss_sleeping)
    |=> st == pss_pkg::pss_working && power_on && !sleep ##1 power_on)
    else $error("sleep short press");

  // long press while sleeping powers off at expiry
  a_long_slp_off: assert property (
    @(posedge clock) disable iff (!nrst)
    (pressed && !expired && st == pss_pkg::pss_sleeping
     && hold == `PSS_CNT_W'(HOLD_CYC - 1))
    |=> st == pss_pkg::pss_soft_off && !power_on && !sleep)
    else $error("sleep long press");

  // long press from soft off leaves the board off
  a_long_off_stay: assert property (
    @(posedge clock) disable iff (!nrst)
    (pressed && !expired && st == pss_pkg::pss_soft_off
     && hold == `PSS_CNT_W'(HOLD_CYC - 1))
    |=> st == pss_pkg::pss_soft_off && !power_on && !sleep)
    else $error("off long press");

  // reaching the threshold marks the hold as spent
  a_expire_set: assert property (
    @(posedge clock) disable iff (!nrst)
    (pressed && !expired && hold == `PSS_CNT_W'(HOLD_CYC - 1))
    |=> expired)
    else $error("timer did not expire");

  // below the threshold the timer counts one per cycle
  a_hold_count: assert property (
    @(posedge clock) disable iff (!nrst)
    (pressed && !expired && hold != `PSS_CNT_W'(HOLD_CYC - 1))
    |=> !expired && hold == $past(hold) + `PSS_CNT_W'(1))
    else $error("timer count");

  // a spent hold changes nothing while still held
  a_expired_hold: assert property (
    @(posedge clock) disable iff (!nrst)
    expired && pressed |=> $stable(st))
    else $error("state moved");

  // the release that ends a spent hold changes nothing
  a_spent_release: assert property (
    @(posedge clock) disable iff (!nrst)
    !pressed && was_pressed && expired |=> $stable(st))
    else $error("state moved on release");

  // no press, no move
  a_quiet_state: assert property (
    @(posedge clock) disable iff (!nrst)
    !pressed && !was_pressed |=> $stable(st))
    else $error("state moved without press");

  // release clears the timer
  a_timer_clear: assert property (
    @(posedge clock) disable iff (!nrst)
    !pressed |=> hold == '0 && !expired)
    else $error("timer");

  // pins follow the state
  a_out_match: assert property (
    @(posedge clock) disable iff (!nrst)
    gstate == 3'(st) && power_on == (st == pss_pkg::pss_working)
    && sleep == (st == pss_pkg::pss_sleeping))
    else $error("outputs");

  // exactly one global state shown
  a_state_onehot: assert property (
    @(posedge clock) disable iff (!nrst)
    $onehot(gstate))
    else $error("state not one-hot");

  // power and sleep levels never both high
  a_levels_excl: assert property (
    @(posedge clock) disable iff (!nrst)
    !(power_on && sleep))
    else $error("power and sleep together");

  // reset lands in soft off with both levels low
  a_reset_off: assert property (
    @(posedge clock)
    !nrst |=> st == pss_pkg::pss_soft_off && !power_on && !sleep
    && gstate == 3'(pss_pkg::pss_soft_off))
    else $error("reset state");
endmodule : pss_power_switch
`default_nettype wire

/* File: verif/pss_switch.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// push switch model with contact chatter
module pss_switch (
  input wire logic clock,
  input wire logic push,
  output logic raw
);
  logic last = 1'h0;
  logic [1:0] n = 2'h0;
  // chatter for three cycles after each change
  always @(posedge clock) begin
    last <= push;
    n <= (push != last) ? 2'h3 : ((n != 2'h0) ? n - 2'h1 : 2'h0);
  end
  assign raw = push ^ n[0];
endmodule : pss_switch
`default_nettype wire

/* File: verif/pss_power_switch_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// power switch bench
module pss_power_switch_tb;
  localparam int DEB = 4;
  localparam int HOLD = 50;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic push = 1'h0;
  logic raw;
  logic [2:0] gstate;
  logic power_on;
  logic sleep;
  int miscompares = 0;
  int checks = 0;
  initial forever #20 clock = ~clock;
  pss_switch pss_switch_i (.clock(clock), .push(push), .raw(raw));
  pss_power_switch #(.HOLD_CYC(HOLD), .DEB_CYC(DEB)) pss_power_switch_i (
    .clock(clock), .nrst(nrst), .sw_pressed(raw), .gstate(gstate),
    .power_on(power_on), .sleep(sleep));
  // drive just after the rising edge
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // hold the switch, release, let debounce settle
  task press(input int len);
    push = 1'h1;
    step(len);
    push = 1'h0;
    step(DEB + 6);
  endtask : press
  task chk(input string what, input pss_pkg::pss_state_t e);
    logic [4:0] x;
    x = {e, e == pss_pkg::pss_working, e == pss_pkg::pss_sleeping};
    checks++;
    if ({gstate, power_on, sleep} !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, x,
        {gstate, power_on, sleep});
    end
  endtask : chk
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // =====================================================
  // scenarios
  task t_glitch;
    press(2);
    chk("glitch", pss_pkg::pss_soft_off);
    press(70);
    chk("long in off", pss_pkg::pss_soft_off);
    $display("test done: t_glitch");
  endtask : t_glitch
  task t_cycle;
    press(20);
    chk("on", pss_pkg::pss_working);
    press(20);
    chk("sleep", pss_pkg::pss_sleeping);
    press(20);
    chk("wake", pss_pkg::pss_working);
    $display("test done: t_cycle");
  endtask : t_cycle
  task t_kill;
    press(70);
    chk("kill working", pss_pkg::pss_soft_off);
    $display("test done: t_kill");
  endtask : t_kill
  task t_sleep_off;
    press(20);
    chk("on again", pss_pkg::pss_working);
    press(20);
    chk("sleep again", pss_pkg::pss_sleeping);
    press(70);
    chk("kill sleeping", pss_pkg::pss_soft_off);
    $display("test done: t_sleep_off");
  endtask : t_sleep_off
  // one cycle either side of the threshold
  task t_edge;
    press(HOLD - 1);
    chk("just short", pss_pkg::pss_working);
    press(HOLD);
    chk("just long", pss_pkg::pss_soft_off);
    $display("test done: t_edge");
  endtask : t_edge
  // reset in mid-run from working
  task t_reset;
    press(20);
    chk("on before reset", pss_pkg::pss_working);
    nrst = 1'h0;
    step(3);
    chk("mid reset", pss_pkg::pss_soft_off);
    nrst = 1'h1;
    step(2);
    chk("after reset", pss_pkg::pss_soft_off);
    press(20);
    chk("on after reset", pss_pkg::pss_working);
    $display("test done: t_reset");
  endtask : t_reset
  // main sequence
  initial begin
    step(5);
    chk("reset", pss_pkg::pss_soft_off);
    nrst = 1'h1;
    step(2);
    t_glitch();
    t_cycle();
    t_kill();
    t_sleep_off();
    t_edge();
    t_reset();
    finish_test();
  end
endmodule : pss_power_switch_tb
`default_nettype wire
